// ===== src/hbf_filter.sv
// Purpose: Fixed half-band low-pass filter, decimate / interpolate / pass.
// Assumes: One clock, synchronous reset, Wishbone classic control port.
// Notes: Latency and tap span follow the pipeline depths in hbf_pkg.
// Functional notes
// RULE1: Every register runs on the rising edge of the one clock.
// RULE2: Source holds frame_align high one edge, then low with first word.
// RULE3: Source keeps frame_align low afterwards or toggles it at half rate.
// RULE4: Interpolate source presents words on the first low edge, then every second.
// RULE5: frame_align is ignored in pass-through mode.
// RULE6: A 12-bit two's complement sample is registered every edge.
// RULE7: Overflow saturates the result to 7FFF or 8000.
// RULE8: Mode code: equal selects pass-through, 0,1 interpolate, 1,0 decimate.
// RULE9: Interpolate mode zeroes every second input sample.
// RULE10: Decimate mode loads the output register on every second edge.
// RULE11: Output rate is half, equal or double the input rate per mode.
// RULE12: Result is always rounded before the output register, 16 to 9 bits.
// RULE13: round_select moves effective LSB; half-LSB added, lower bits cleared.
// RULE14: twos_comp_select low inverts all bits but the MSB.
// RULE15: Active-low enable drives the result pins, else they float.
// RULE16: Impulse peak reaches the output 33 cycles after input.
// RULE17: Response spans 55 values from cycle 6 to cycle 60.
// RULE18: DC gain 1.0015 in pass and decimate, 0.5007 interpolating.
// RULE19: Symmetric half-band tap values fit tap count, latency and gain.
// RULE20: Pipeline contents are meaningless until flushed by input samples.
`timescale 1ns/1ps

module hbf_filter
  import hbf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [HBF_SAMPLE_W-1:0] sample_in_i,
  input wire logic frame_align_i,
  input wire logic output_enable_n_i,
  output logic [HBF_RESULT_W-1:0] result_out_o,
  output logic result_oe_o
);

  logic [5:0] ctrl;
  logic ack_q;
  logic [31:0] rd_q;
  logic data_flag;
  logic signed [HBF_SAMPLE_W-1:0] in_q;
  logic signed [HBF_SAMPLE_W-1:0] align_q [0:HBF_ALIGN-1];
  logic signed [HBF_SAMPLE_W-1:0] x_line [0:HBF_TAPS-1];
  logic signed [HBF_ACC_W-1:0] acc_q;
  logic [HBF_RESULT_W-1:0] rnd_q;
  logic [HBF_RESULT_W-1:0] out_q;

  // Register port decode
  wire logic bus_hit = wb_cyc_i & wb_stb_i;
  wire logic hit_ctrl = (wb_adr_i == HBF_CTRL_ADDR);
  wire logic hit_stat = (wb_adr_i == HBF_STAT_ADDR);
  wire logic ctrl_wr = bus_hit & ack_q & wb_we_i & wb_sel_i[0] & hit_ctrl;

  wire logic int_select_n = ctrl[HBF_CTRL_INTN_BIT];
  wire logic decim_select_n = ctrl[HBF_CTRL_DECN_BIT];
  wire logic [2:0] round_select = ctrl[HBF_CTRL_RND_LSB +: 3];
  wire logic twos_comp_select = ctrl[HBF_CTRL_TCO_BIT];

  hbf_mode_t mode;
  assign mode = (int_select_n == decim_select_n) ? HBF_MODE_PASS : // [RULE8]
                (!int_select_n ? HBF_MODE_INTERP : HBF_MODE_DECIM);
  wire logic is_pass = (mode == HBF_MODE_PASS);
  wire logic is_interp = (mode == HBF_MODE_INTERP);
  wire logic is_decim = (mode == HBF_MODE_DECIM);

  wire logic [31:0] stat_word = {12'h000, mode, data_flag, out_q};
  wire logic [31:0] rd_mux = hit_ctrl ? {26'h0000000, ctrl} :
                             (hit_stat ? stat_word : 32'h00000000);

  // Ack is registered, so it drops the cycle after the master sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else begin
      ack_q <= bus_hit & ~ack_q;
      if (bus_hit & ~ack_q) begin
        rd_q <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= HBF_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= wb_dat_i[5:0];
    end
  end

  // Half-rate phase: set by frame_align, free-running toggle otherwise
  wire logic next_data_flag = (frame_align_i & ~is_pass) ? 1'b1 : ~data_flag; // [RULE2] [RULE5]

  // Zero stuffing halves input rate and DC gain when interpolating
  wire logic signed [HBF_SAMPLE_W-1:0] next_in =
    (is_interp & ~data_flag) ? '0 : sample_in_i; // [RULE9] [RULE4] [RULE6]

  // Decimation keeps only every second filter result
  wire logic out_load = ~is_decim | data_flag; // [RULE10] [RULE11]

  // Pipeline is cleared at reset so outputs are defined before the flush
  always_ff @(posedge clk_i) begin // [RULE1] [RULE20]
    if (rst_i) begin
      data_flag <= 1'b0;
      in_q <= '0;
      for (int i = 0; i < HBF_ALIGN; i++) begin
        align_q[i] <= '0;
      end
      for (int i = 0; i < HBF_TAPS; i++) begin
        x_line[i] <= '0;
      end
    end else begin
      data_flag <= next_data_flag;
      in_q <= next_in;
      align_q[0] <= in_q;
      for (int i = 1; i < HBF_ALIGN; i++) begin
        align_q[i] <= align_q[i-1];
      end
      x_line[0] <= align_q[HBF_ALIGN-1]; // [RULE17]
      for (int i = 1; i < HBF_TAPS; i++) begin
        x_line[i] <= x_line[i-1];
      end
    end
  end

  // Symmetric pairs share one multiplier; even offsets other than the centre are zero taps
  logic signed [HBF_ACC_W-1:0] pair_prod [0:HBF_PAIRS-1];

  for (genvar j = 0; j < HBF_PAIRS; j++) begin : g_pair
    wire logic signed [HBF_SAMPLE_W:0] pair_sum =
      (HBF_SAMPLE_W+1)'(x_line[HBF_CENTER-(2*j+1)]) +
      (HBF_SAMPLE_W+1)'(x_line[HBF_CENTER+(2*j+1)]);
    assign pair_prod[j] = HBF_ACC_W'(pair_sum) * HBF_ACC_W'(HBF_COEF[j]); // [RULE19]
  end

  wire logic signed [HBF_ACC_W-1:0] center_prod =
    HBF_ACC_W'(x_line[HBF_CENTER]) * HBF_ACC_W'(HBF_CENTER_COEF); // [RULE16]

  logic signed [HBF_ACC_W-1:0] next_acc;

  always_comb begin
    next_acc = center_prod;
    for (int j = 0; j < HBF_PAIRS; j++) begin
      next_acc = next_acc + pair_prod[j]; // [RULE18]
    end
  end

  // Rounding: half-LSB in, lower bits cleared, then saturation
  wire logic [4:0] rnd_pos = 5'(HBF_FRAC_W) + {2'b00, round_select};
  wire logic signed [HBF_ACC_W-1:0] half_lsb = HBF_ACC_W'(1) <<< (rnd_pos - 5'd1);
  wire logic signed [HBF_ACC_W-1:0] keep_mask = ~((HBF_ACC_W'(1) <<< rnd_pos) - HBF_ACC_W'(1));
  wire logic signed [HBF_ACC_W-1:0] rounded = (acc_q + half_lsb) & keep_mask; // [RULE12] [RULE13]
  wire logic signed [HBF_ACC_W-1:0] scaled = rounded >>> HBF_FRAC_W;
  wire logic sat_pos = (scaled > HBF_POS_FULL);
  wire logic sat_neg = (scaled < HBF_NEG_FULL);
  wire logic [HBF_RESULT_W-1:0] next_rnd =
    sat_pos ? 16'h7FFF : (sat_neg ? 16'h8000 : scaled[HBF_RESULT_W-1:0]); // [RULE7]

  // Format applied ahead of the output register keeps pins glitch-free
  wire logic [HBF_RESULT_W-1:0] next_out =
    twos_comp_select ? rnd_q : {rnd_q[15], ~rnd_q[14:0]}; // [RULE14]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
      rnd_q <= 16'h0000;
      out_q <= 16'h0000;
    end else begin
      acc_q <= next_acc;
      rnd_q <= next_rnd;
      if (out_load) begin
        out_q <= next_out;
      end
    end
  end

  // Enable is combinational from the pin, so it acts without the clock
  assign result_out_o = out_q;
  assign result_oe_o = ~output_enable_n_i; // [RULE15]

  // Cycles since reset, saturating at 63; each delay check waits until its own stage has filled
  logic [5:0] flush_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_cnt <= 6'h00;
    end else if (flush_cnt != 6'h3F) begin
      flush_cnt <= flush_cnt + 6'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_pass_full_rate: assert property ( // [RULE8]
    is_pass |-> out_load
  ) else $error("pass-through did not load output every cycle");

  chk_decim_alternate: assert property ( // [RULE10]
    (is_decim && out_load && !frame_align_i) ##1 is_decim |->
      !out_load ##1 (!is_decim || out_load)
  ) else $error("decimate output load not on alternate edges");

  chk_decim_hold: assert property ( // [RULE10]
    is_decim && !out_load |=> $stable(out_q)
  ) else $error("decimate output changed on skipped edge");

  chk_interp_zero: assert property ( // [RULE9]
    is_interp && !data_flag |=> in_q == '0
  ) else $error("interpolate stuffed sample not zero");

  chk_input_capture: assert property ( // [RULE6]
    is_pass |=> in_q == $past(sample_in_i)
  ) else $error("input sample not registered");

  chk_align_phase: assert property ( // [RULE2]
    frame_align_i && !is_pass ##1 !frame_align_i |-> data_flag ##1 !data_flag
  ) else $error("frame alignment did not set sample phase");

  chk_center_delay: assert property ( // [RULE16]
    flush_cnt >= 6'(HBF_CENTER + HBF_ALIGN + 1) |->
      x_line[HBF_CENTER] == $past(in_q, HBF_CENTER + HBF_ALIGN + 1)
  ) else $error("centre tap delay wrong");

  chk_entry_delay: assert property ( // [RULE17]
    flush_cnt >= 6'(HBF_ALIGN + 1) |-> x_line[0] == $past(in_q, HBF_ALIGN + 1)
  ) else $error("first tap delay wrong");

  chk_tail_delay: assert property ( // [RULE17]
    flush_cnt >= 6'(HBF_TAPS + HBF_ALIGN) |->
      x_line[HBF_TAPS-1] == $past(in_q, HBF_TAPS + HBF_ALIGN)
  ) else $error("last tap delay wrong");

  chk_align_ignored: assert property ( // [RULE5]
    is_pass |=> data_flag != $past(data_flag)
  ) else $error("pass-through phase did not free-run");

  chk_interp_phase: assert property ( // [RULE4]
    is_interp && !frame_align_i |=> data_flag != $past(data_flag)
  ) else $error("interpolate phase did not alternate");

  chk_interp_keep: assert property ( // [RULE9]
    is_interp && data_flag |=> in_q == $past(sample_in_i)
  ) else $error("interpolate data sample lost");

  chk_twos_format: assert property ( // [RULE14]
    twos_comp_select && out_load |=> out_q == $past(rnd_q)
  ) else $error("two's complement format wrong");

  chk_enable_pin: assert property ( // [RULE15]
    result_oe_o == !output_enable_n_i
  ) else $error("output enable does not follow pin");

  chk_mode_onehot: assert property ( // [RULE8]
    $onehot(mode)
  ) else $error("mode decode not one-hot");

  chk_write_lands: assert property ( // [RULE8]
    ctrl_wr |=> ctrl == $past(wb_dat_i[5:0])
  ) else $error("control write did not land");

  chk_ack_idle: assert property (
    !bus_hit |=> !wb_ack_o
  ) else $error("acknowledge without request");

  chk_sat_clamp: assert property ( // [RULE7]
    (sat_pos |=> rnd_q == 16'h7FFF) and (sat_neg |=> rnd_q == 16'h8000)
  ) else $error("overflow not saturated");

  chk_round_clear: assert property ( // [RULE13]
    !sat_pos && !sat_neg |=>
      (rnd_q & ((16'h0001 << $past(round_select)) - 16'h0001)) == 16'h0000
  ) else $error("bits below effective LSB not cleared");

  chk_offset_format: assert property ( // [RULE14]
    !twos_comp_select && out_load |=>
      out_q == {$past(rnd_q[15]), ~$past(rnd_q[14:0])}
  ) else $error("offset binary format wrong");

  chk_bus_ack: assert property (
    bus_hit && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("bus acknowledge not a single cycle");

  cov_interp_out: cover property (is_interp && out_load && out_q != 16'h0000);
  cov_decim_run: cover property (is_decim [*4]);
  cov_saturate: cover property (sat_pos);
  cov_realign: cover property (frame_align_i && !is_pass ##1 !frame_align_i);
  cov_round_max: cover property (round_select == 3'h7 && out_load);

endmodule : hbf_filter

// ===== src/hbf_pkg.sv
// Purpose: Shared constants and types for the half-band filter block.
// Assumes: 200 MHz clk_i, classic Wishbone register port.
// Notes: Tap values are fixed Q15 figures, symmetric about the centre.
package hbf_pkg;

  localparam int HBF_SAMPLE_W = 12;
  localparam int HBF_RESULT_W = 16;
  localparam int HBF_ACC_W = 34;
  localparam int HBF_FRAC_W = 11;
  localparam int HBF_TAPS = 55;
  localparam int HBF_CENTER = 27;
  localparam int HBF_PAIRS = 14;
  localparam int HBF_ALIGN = 2;
  localparam int HBF_FIRST_OUT = 6;
  localparam int HBF_PEAK_OUT = 33;
  localparam int HBF_LAST_OUT = 60;

  // Centre tap is one half; pair k sits at offset 2k+1 from the centre
  localparam logic signed [15:0] HBF_CENTER_COEF = 16'sh4000;
  localparam logic signed [15:0] HBF_COEF [0:HBF_PAIRS-1] = '{
    16'sh28A3, 16'shF2FE, 16'sh0744, 16'shFB50, 16'sh033E, 16'shFDB2, 16'sh01A4,
    16'shFED9, 16'sh00C8, 16'shFF7E, 16'sh0050, 16'shFFD2, 16'sh0016, 16'shFFF8};

  localparam logic [3:0] HBF_CTRL_ADDR = 4'h0;
  localparam logic [3:0] HBF_STAT_ADDR = 4'h4;
  localparam int HBF_CTRL_INTN_BIT = 0;
  localparam int HBF_CTRL_DECN_BIT = 1;
  localparam int HBF_CTRL_RND_LSB = 2;
  localparam int HBF_CTRL_TCO_BIT = 5;
  localparam logic [5:0] HBF_CTRL_RESET = 6'h23;
  localparam int HBF_STAT_FLAG_BIT = 16;
  localparam int HBF_STAT_MODE_LSB = 17;

  localparam logic signed [HBF_ACC_W-1:0] HBF_POS_FULL = 34'sh000007FFF;
  localparam logic signed [HBF_ACC_W-1:0] HBF_NEG_FULL = 34'sh3FFFF8000;

  typedef enum logic [2:0] {
    HBF_MODE_PASS = 3'h1,
    HBF_MODE_INTERP = 3'h2,
    HBF_MODE_DECIM = 3'h4
  } hbf_mode_t;

endpackage : hbf_pkg

// ===== verif/halfband_interp_decim_filter_tb.sv
// Purpose: Self-checking bench for the half-band filter.
// Assumes: 200 MHz clock, synchronous active-high reset.
// Notes: Bus first, then row table, decimate, enable, reset.
`timescale 1ns/1ps

module halfband_interp_decim_filter_tb import hbf_pkg::*;;
  typedef struct {
    logic [5:0] c;
    logic [11:0] s;
    int d;
    bit al;
    int g;
    logic [15:0] e;
  } hbf_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic oe_n = 1'b0;
  logic [31:0] rdat, rd;
  logic [11:0] smp;
  logic [15:0] res, prev;
  logic ack, fa, oe;
  int err_total = 0;
  int total_checks = 0;
  int chg, last;
  // Pipeline is flushed with zeros between rows, so each row stands alone
  hbf_row_t rows [16] = '{
    '{6'h23, 12'h7FF, 33, 0, 0, 16'h3FF8}, '{6'h33, 12'h7FF, 33, 0, 0, 16'h4000},
    '{6'h3F, 12'h7FF, 33, 0, 0, 16'h4000}, '{6'h33, 12'hFFF, 33, 0, 0, 16'h0000},
    '{6'h03, 12'h7FF, 33, 0, 0, 16'h4007}, '{6'h20, 12'h400, 33, 0, 0, 16'h2000},
    '{6'h23, 12'h800, 33, 0, 0, 16'hC000}, '{6'h23, 12'h400, 5, 0, 0, 16'h0000},
    '{6'h23, 12'h400, 6, 0, 0, 16'hFFFC}, '{6'h23, 12'h400, 60, 0, 0, 16'hFFFC},
    '{6'h23, 12'h400, 61, 0, 0, 16'h0000}, '{6'h23, 12'h7FF, 0, 0, 0, 16'h7FFF},
    '{6'h23, 12'h800, 0, 0, 0, 16'h8000}, '{6'h22, 12'h400, 33, 1, 0, 16'h2000},
    '{6'h22, 12'h400, 33, 1, 1, 16'h0000}, '{6'h23, 12'h400, 33, 1, 1, 16'h2000}};

  always #2.5 clk_i = ~clk_i;

  hbf_filter i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .sample_in_i(smp), .frame_align_i(fa), .output_enable_n_i(oe_n),
    .result_out_o(res), .result_oe_o(oe));
  hbf_source i_src (.clk_i(clk_i), .sample_o(smp), .align_o(fa));

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Holds the request until ack is sampled, bounded wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    sel <= s;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    if (n >= 20) err_total++;
  endtask : wb

  task automatic summarize();
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    #100000;
    err_total++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, HBF_CTRL_ADDR, 32'h0);
    cmp("ctrl", 32'h23, rd);
    wb(1'b0, HBF_STAT_ADDR, 32'h0);
    cmp("mode", 32'h1, {29'h0, rd[19:17]});
    wb(1'b1, 4'h8, 32'hFFFFFFFF);
    wb(1'b0, 4'h8, 32'h0);
    cmp("unmapped", 32'h0, rd);
    wb(1'b1, HBF_CTRL_ADDR, 32'h22, 4'h0);
    wb(1'b0, HBF_CTRL_ADDR, 32'h0);
    cmp("ctrl_nosel", 32'h23, rd);
    foreach (rows[i]) begin
      wb(1'b1, HBF_CTRL_ADDR, {26'h0, rows[i].c});
      if (rows[i].d == 0) begin
        i_src.level(rows[i].s);
        repeat (70) @(posedge clk_i);
      end else begin
        i_src.send(rows[i].s, rows[i].al, rows[i].g);
        repeat (rows[i].d) @(posedge clk_i);
      end
      #1;
      cmp("result", {16'h0, rows[i].e}, {16'h0, res});
      i_src.level(12'h000);
      repeat (64) @(posedge clk_i);
    end
    // Decimated output may never change on two edges running
    wb(1'b1, HBF_CTRL_ADDR, 32'h21);
    // Align so loads fall on the phase that carries the outer taps
    i_src.send(12'h7FF, 1'b1, 0);
    #1;
    prev = res;
    last = -9;
    chg = 0;
    for (int k = 1; k < 64; k++) begin
      @(posedge clk_i);
      #1;
      if (res !== prev) begin
        if (k == last + 1) chg++;
        last = k;
      end
      prev = res;
    end
    cmp("decim_adjacent", 32'h0, chg);
    cmp("decim_span", 32'h1, 32'(last > 58 && last < 64));
    @(posedge clk_i);
    oe_n <= 1'b1;
    #1;
    cmp("oe_off", 32'h0, {31'h0, oe});
    @(posedge clk_i);
    oe_n <= 1'b0;
    #1;
    cmp("oe_on", 32'h1, {31'h0, oe});
    wb(1'b1, HBF_CTRL_ADDR, 32'h3F);
    i_src.level(12'h7FF);
    repeat (40) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    cmp("rst_result", 32'h0, {16'h0, res});
    wb(1'b0, HBF_CTRL_ADDR, 32'h0);
    cmp("rst_ctrl", 32'h23, rd);
    summarize();
  end
endmodule : halfband_interp_decim_filter_tb

// ===== verif/hbf_source.sv
// Purpose: Sample source on the filter stream input.
// Assumes: Shares clk_i; changes only after rising edges.
// Notes: Always drives; send puts zero between words, level holds its word.
`timescale 1ns/1ps

module hbf_source (
  input wire logic clk_i,
  output logic [11:0] sample_o,
  output logic align_o
);
  initial begin
    sample_o = 12'h000;
    align_o = 1'b0;
  end

  // Optional align pulse, word gap edges after the first low edge
  task automatic send(input logic [11:0] v, input bit al, input int gap);
    @(posedge clk_i);
    if (al) begin
      align_o <= 1'b1;
      @(posedge clk_i);
    end
    align_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
    sample_o <= v;
    @(posedge clk_i);
    sample_o <= 12'h000;
  endtask : send

  task automatic level(input logic [11:0] v);
    @(posedge clk_i);
    sample_o <= v;
  endtask : level
endmodule : hbf_source
